// [design/modem_hif.sv]
// Host interface control/status bank of the modem data pump.
// Assumes an asynchronous 8-bit host bus on pins, core signals on clk_in.
`timescale 1ns/1ns
module modem_hif #(
  parameter int MS_TICK_CYCLES = modem_hif_pkg::MS_CYCLES
) (
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  // Host bus pins
  input  wire logic        cs_n_in,
  input  wire logic        rd_n_in,
  input  wire logic        wr_n_in,
  input  wire logic [4:0]  addr_in,
  input  wire logic [7:0]  data_in,
  output logic [7:0]       data_out,
  output logic             data_oe_out,
  output logic             irq_out,
  // Line pins
  input  wire logic        ring_detect_in,
  input  wire logic        rts_pin_in,
  output logic             ring_indicator_out,
  output logic             line_signal_detect_out,
  output logic             offhook_relay_out,
  output logic             relay_out_a,
  // Modem core side
  input  wire logic        config_applied_in,
  input  wire logic [modem_hif_pkg::STAT_W-1:0] core_status_in,
  input  wire logic [modem_hif_pkg::STAT_W-1:0] status_mask_in,
  input  wire logic        ram_done_in,
  input  wire logic        data_mode_in,
  input  wire logic        sync_mode_in,
  input  wire logic        async_mode_in,
  input  wire logic        hdlc_par_mode_in,
  input  wire logic        cts_in,
  input  wire logic        rx_byte_valid_in,
  input  wire logic [7:0]  rx_byte_in,
  input  wire logic        rx_par_bit_in,
  input  wire logic        frame_check_bad_in,
  input  wire logic [7:0]  tx_char_in,
  input  wire logic        ontime_met_in,
  input  wire logic        offtime_fail_in,
  input  wire logic        tx_bit_stb_in,
  input  wire logic        tx_user_bit_in,
  input  wire logic        rx_bit_stb_in,
  input  wire logic        rx_line_bit_in,
  output logic             tx_line_bit_out,
  output logic             rx_data_bit_out,
  output logic             tx_parity_bit_out,
  output logic             config_update_request_out,
  output logic             answer_tone_suppress_out,
  output logic [1:0]       energy_threshold_select_out,
  output logic             tx_data_enable_out,
  output logic             sleep_out
);
  import modem_hif_pkg::*;

  // Pin synchronisers, first stage read only by second
  logic [17:0] pin_s1_r, pin_s2_r;
  logic        ring_s2_d_r;
  logic        strobe_wr_d_r, strobe_rd_d_r;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_s1_r <= {3'b111, 15'h0000};
      pin_s2_r <= {3'b111, 15'h0000};
    end else begin
      pin_s1_r <= {cs_n_in, rd_n_in, wr_n_in, addr_in, data_in,
                   ring_detect_in, rts_pin_in};
      pin_s2_r <= pin_s1_r;
    end
  end

  wire       cs_n_s  = pin_s2_r[17];
  wire       rd_n_s  = pin_s2_r[16];
  wire       wr_n_s  = pin_s2_r[15];
  wire [4:0] addr_s  = pin_s2_r[14:10];
  wire [7:0] wdata_s = pin_s2_r[9:2];
  wire       ring_s  = pin_s2_r[1];
  wire       rts_s   = pin_s2_r[0];

  // Host strobes and their edges
  wire strobe_wr = ~cs_n_s & ~wr_n_s;
  wire strobe_rd = ~cs_n_s & ~rd_n_s;
  wire host_wr   = strobe_wr & ~strobe_wr_d_r;
  wire rd_done   = ~strobe_rd & strobe_rd_d_r;

  logic [7:0] mem_r [0:31];
  logic [4:0] rd_addr_r;
  logic [7:0] rx_data_r;
  logic       cfg_req_r, stat_flag_r, cfg_act_r, stat_act_r;
  logic       rx_full_r, rx_act_r, overrun_r, par_err_r;
  logic       ontime_r, sleep_r, ring_stat_r;
  logic [STAT_W-1:0] stat_prev_r;

  // Stored control bytes, one per offset
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_reg
      always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in)
          mem_r[gi] <= reg_reset(gi);
        else if (host_wr && addr_s == 5'(gi) && gi != 0)
          mem_r[gi] <= wdata_s;
      end
    end
  endgenerate

  // Named control fields
  wire sd_pin_en   = mem_r[OFS_SIG_CTRL][BIT_SD_PIN_EN];
  wire nrzi_en     = mem_r[OFS_LINE_CTRL][BIT_NRZI_EN];
  wire par_en      = mem_r[OFS_ASYNC][BIT_PAR_EN];
  wire rts_bit     = mem_r[OFS_TX_CTRL][BIT_RTS];
  wire rrts_en     = mem_r[OFS_DIAL][BIT_RRTS_EN];
  wire ring_wake   = mem_r[OFS_POWER][BIT_RING_WAKE];
  wire host_wake   = mem_r[OFS_POWER][BIT_HOST_WAKE];
  wire ri_ovr_en   = mem_r[OFS_RING][BIT_RI_OVR_EN];
  wire ri_ovr_lvl  = mem_r[OFS_RING][BIT_RI_OVR_LVL];
  wire rx_irq_en   = mem_r[OFS_BUF_IRQ][BIT_RX_IRQ_EN];
  wire cfg_irq_en  = mem_r[OFS_CFG_IRQ][BIT_CFG_IRQ_EN];
  wire stat_irq_en = mem_r[OFS_CFG_IRQ][BIT_STAT_IRQ_EN];
  wire [1:0] par_sel = mem_r[OFS_PARITY][BIT_PAR_SEL_LO+1:BIT_PAR_SEL_LO];
  wire [1:0] thr_sel = mem_r[OFS_LEVEL][BIT_THR_LO+1:BIT_THR_LO];

  // Host write and read decode for flag bytes
  wire wr_cfg  = host_wr && addr_s == OFS_CFG_IRQ;
  wire wr_stat = host_wr && addr_s == OFS_STAT_LO;
  wire wr_pwr  = host_wr && addr_s == OFS_POWER;
  wire rd_rbuf = rd_done && rd_addr_r == OFS_RX_DATA;

  // Status vector with own bits merged in
  logic [STAT_W-1:0] stat_all;
  always_comb begin
    stat_all = core_status_in;
    stat_all[BIT_OVERRUN] = overrun_r;
    stat_all[BIT_PAR_ERR] = par_err_r;
    stat_all[5*8+BIT_RING_STAT] = ring_stat_r;
    stat_all[SV_TONE_IDX*8+BIT_ONTIME] = ontime_r;
  end
  wire stat_change = |((stat_all ^ stat_prev_r) & ~status_mask_in);
  wire digit_rise  = stat_all[SV_TONE_IDX*8+BIT_DIGIT_DET]
                   & ~stat_prev_r[SV_TONE_IDX*8+BIT_DIGIT_DET];

  // Parity of a character by method
  function automatic logic par_of(input logic [1:0] sel,
                                  input logic [7:0] d);
    case (parity_e'(sel))
      PAR_STUFF: par_of = 1'b1;
      PAR_SPACE: par_of = 1'b0;
      PAR_EVEN:  par_of = ^d;
      PAR_ODD:   par_of = ~^d;
      default:   par_of = 1'b0;
    endcase
  endfunction : par_of

  wire rx_par_bad = async_mode_in & par_en
                  & (par_of(par_sel, rx_byte_in) != rx_par_bit_in);
  wire par_err_set = rx_byte_valid_in
                   & (rx_par_bad | (hdlc_par_mode_in & frame_check_bad_in));
  wire ovr_set = rx_byte_valid_in & rx_full_r
               & (async_mode_in | hdlc_par_mode_in);

  // Configuration and status flags, set wins over clear
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cfg_req_r   <= 1'b0;
      cfg_act_r   <= 1'b0;
      stat_flag_r <= 1'b0;
      stat_act_r  <= 1'b0;
      stat_prev_r <= '0;
    end else begin
      stat_prev_r <= stat_all;
      if (wr_cfg && wdata_s[BIT_CFG_REQ])
        cfg_req_r <= 1'b1;
      else if (config_applied_in)
        cfg_req_r <= 1'b0;
      if (config_applied_in && cfg_req_r && cfg_irq_en)
        cfg_act_r <= 1'b1;
      else if (wr_cfg && !wdata_s[BIT_CFG_IRQ_ACT])
        cfg_act_r <= 1'b0;
      if (stat_change || ram_done_in)
        stat_flag_r <= 1'b1;
      else if (wr_cfg && !wdata_s[BIT_STAT_FLAG])
        stat_flag_r <= 1'b0;
      stat_act_r <= stat_irq_en & stat_flag_r;
    end
  end

  // Receive buffer, overrun and parity error
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rx_data_r <= 8'h00;
      rx_full_r <= 1'b0;
      rx_act_r  <= 1'b0;
      overrun_r <= 1'b0;
      par_err_r <= 1'b0;
    end else begin
      if (rx_byte_valid_in)
        rx_data_r <= rx_byte_in;
      if (rx_byte_valid_in)
        rx_full_r <= 1'b1;
      else if (rd_rbuf)
        rx_full_r <= 1'b0;
      if (rx_byte_valid_in && rx_irq_en)
        rx_act_r <= 1'b1;
      else if (rd_rbuf)
        rx_act_r <= 1'b0;
      if (ovr_set)
        overrun_r <= 1'b1;
      else if (wr_stat && !wdata_s[BIT_OVERRUN])
        overrun_r <= 1'b0;
      if (par_err_set)
        par_err_r <= 1'b1;
      else if (wr_stat && !wdata_s[BIT_PAR_ERR])
        par_err_r <= 1'b0;
    end
  end

  // Ring period measurement in milliseconds
  logic [16:0] ms_cnt_r;
  logic [6:0]  period_r;
  wire ms_tick   = ms_cnt_r == 17'(MS_TICK_CYCLES - 1);
  wire ring_edge = ring_s & ~ring_s2_d_r;
  wire period_ok = period_r >= RING_PMIN_MS && period_r <= RING_PMAX_MS;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ms_cnt_r    <= '0;
      period_r    <= '0;
      ring_s2_d_r <= 1'b0;
      ring_stat_r <= 1'b0;
    end else begin
      ring_s2_d_r <= ring_s;
      ms_cnt_r <= ms_tick ? '0 : ms_cnt_r + 17'd1;
      if (ring_edge) begin
        period_r <= '0;
        ring_stat_r <= period_ok;
      end else if (ms_tick && period_r != 7'h7F) begin
        period_r <= period_r + 7'd1;
        if (period_r >= RING_PMAX_MS)
          ring_stat_r <= 1'b0;
      end
    end
  end

  // Tone on-time flag and sleep control
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ontime_r <= 1'b0;
      sleep_r  <= 1'b0;
    end else begin
      if (ontime_met_in)
        ontime_r <= 1'b1;
      else if (digit_rise || offtime_fail_in)
        ontime_r <= 1'b0;
      if (wr_pwr && wdata_s[BIT_SLEEP])
        sleep_r <= 1'b1;
      else if (sleep_r && ring_wake && ring_edge)
        sleep_r <= 1'b0;
      else if (sleep_r && host_wake && host_wr && addr_s != OFS_MEM_HI)
        sleep_r <= 1'b0;
    end
  end

  // Remote RTS pattern scrambler
  logic [6:0] scr_r;
  logic [3:0] turn_cnt_r;
  logic       rts_any_d_r, scr_bit_r, scr_stb_r;
  wire rts_any = rts_bit | rts_s;
  wire scr_in  = !rts_any ? 1'b1 : (turn_cnt_r != 0) ? 1'b0
                                                       : tx_user_bit_in;
  wire scr_out = scr_in ^ scr_r[2] ^ scr_r[6];
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      scr_r       <= '0;
      turn_cnt_r  <= '0;
      rts_any_d_r <= 1'b0;
      scr_bit_r   <= 1'b1;
      scr_stb_r   <= 1'b0;
    end else begin
      rts_any_d_r <= rts_any;
      scr_stb_r   <= tx_bit_stb_in;
      if (rts_any && !rts_any_d_r)
        turn_cnt_r <= 4'(TURN_ON_BITS);
      else if (tx_bit_stb_in && turn_cnt_r != 0)
        turn_cnt_r <= turn_cnt_r - 4'd1;
      if (tx_bit_stb_in) begin
        scr_r     <= rrts_en ? {scr_r[5:0], scr_out} : scr_r;
        scr_bit_r <= rrts_en ? scr_out : tx_user_bit_in;
      end
    end
  end

  nrzi_codec u_nrzi (
    .clk_in      (clk_in),
    .nrst_in     (nrst_in),
    .enable_in   (nrzi_en & sync_mode_in),
    .tx_stb_in   (scr_stb_r),
    .tx_bit_in   (scr_bit_r),
    .rx_stb_in   (rx_bit_stb_in),
    .rx_bit_in   (rx_line_bit_in),
    .tx_line_out (tx_line_bit_out),
    .rx_bit_out  (rx_data_bit_out)
  );

  // Read data selection
  logic [7:0] rd_mux;
  wire [4:0] st_idx = (addr_s == OFS_RING) ? 5'(SV_RING_IDX)
                    : (addr_s == OFS_TONE) ? 5'(SV_TONE_IDX)
                    : addr_s - OFS_STAT_LO;
  wire [7:0] st_byte = stat_all[st_idx[2:0]*8 +: 8];
  always_comb begin
    rd_mux = mem_r[addr_s];
    if (addr_s == OFS_RX_DATA)
      rd_mux = rx_data_r;
    else if (addr_s >= OFS_STAT_LO && addr_s <= OFS_STAT_HI)
      rd_mux = st_byte;
    else if (addr_s == OFS_TONE)
      rd_mux = st_byte;
    else if (addr_s == OFS_RING)
      rd_mux = {mem_r[OFS_RING][7:3], st_byte[2:1], mem_r[OFS_RING][0]};
    else if (addr_s == OFS_POWER)
      rd_mux = {sleep_r, mem_r[OFS_POWER][6:0]};
    else if (addr_s == OFS_BUF_IRQ)
      rd_mux = {mem_r[OFS_BUF_IRQ][7], rx_act_r,
                mem_r[OFS_BUF_IRQ][5:1], rx_full_r};
    else if (addr_s == OFS_CFG_IRQ)
      rd_mux = {stat_act_r, cfg_act_r, mem_r[OFS_CFG_IRQ][5],
                stat_irq_en, stat_flag_r, cfg_irq_en,
                mem_r[OFS_CFG_IRQ][1], cfg_req_r};
  end

  // Bus answer and registered pin outputs
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      strobe_wr_d_r <= 1'b0;
      strobe_rd_d_r <= 1'b0;
      rd_addr_r     <= '0;
      data_out      <= 8'h00;
      data_oe_out   <= 1'b0;
      irq_out       <= 1'b0;
      ring_indicator_out <= 1'b1;
      line_signal_detect_out <= 1'b0;
      offhook_relay_out <= 1'b0;
      relay_out_a   <= 1'b0;
      tx_parity_bit_out <= 1'b0;
      config_update_request_out <= 1'b0;
      answer_tone_suppress_out <= 1'b0;
      energy_threshold_select_out <= 2'b00;
      tx_data_enable_out <= 1'b0;
      sleep_out     <= 1'b0;
    end else begin
      strobe_wr_d_r <= strobe_wr;
      strobe_rd_d_r <= strobe_rd;
      if (strobe_rd) begin
        rd_addr_r <= addr_s;
        data_out  <= rd_mux;
      end
      data_oe_out <= strobe_rd;
      irq_out <= cfg_act_r | stat_act_r | rx_act_r;
      ring_indicator_out <= (ri_ovr_en && !data_mode_in)
                          ? ~ri_ovr_lvl : ring_s;
      line_signal_detect_out <= sd_pin_en
        & stat_all[5*8+BIT_SIG_DET];
      offhook_relay_out <= mem_r[OFS_RELAY][BIT_RELAY_A];
      relay_out_a <= mem_r[OFS_LINE_CTRL][BIT_RELAY_B];
      tx_parity_bit_out <= par_en & par_of(par_sel, tx_char_in);
      config_update_request_out <= cfg_req_r;
      answer_tone_suppress_out <= mem_r[OFS_DIAL][BIT_TONE_SUPP];
      energy_threshold_select_out <= thr_sel;
      tx_data_enable_out <= rts_any & cts_in;
      sleep_out <= sleep_r;
    end
  end
endmodule : modem_hif

// [design/modem_hif_pkg.sv]
// Constants for the modem host interface control and status bank.
// Assumes an 8-bit host bus with 32 byte registers, one 125 MHz clock.
package modem_hif_pkg;

  // Register offsets
  localparam logic [4:0] OFS_RX_DATA   = 5'h00;
  localparam logic [4:0] OFS_SIG_CTRL  = 5'h03;
  localparam logic [4:0] OFS_LINE_CTRL = 5'h04;
  localparam logic [4:0] OFS_ASYNC     = 5'h06;
  localparam logic [4:0] OFS_RELAY     = 5'h07;
  localparam logic [4:0] OFS_TX_CTRL   = 5'h08;
  localparam logic [4:0] OFS_DIAL      = 5'h09;
  localparam logic [4:0] OFS_STAT_LO   = 5'h0A;
  localparam logic [4:0] OFS_STAT_HI   = 5'h0F;
  localparam logic [4:0] OFS_PARITY    = 5'h11;
  localparam logic [4:0] OFS_LEVEL     = 5'h13;
  localparam logic [4:0] OFS_POWER     = 5'h15;
  localparam logic [4:0] OFS_RING      = 5'h1A;
  localparam logic [4:0] OFS_TONE      = 5'h1B;
  localparam logic [4:0] OFS_MEM_HI    = 5'h1D;
  localparam logic [4:0] OFS_BUF_IRQ   = 5'h1E;
  localparam logic [4:0] OFS_CFG_IRQ   = 5'h1F;

  // Bit positions
  localparam int BIT_SD_PIN_EN   = 4;  // 03
  localparam int BIT_RELAY_B     = 7;  // 04
  localparam int BIT_NRZI_EN     = 2;  // 04
  localparam int BIT_PAR_EN      = 3;  // 06
  localparam int BIT_RELAY_A     = 1;  // 07
  localparam int BIT_RTS         = 0;  // 08
  localparam int BIT_TONE_SUPP   = 7;  // 09
  localparam int BIT_RRTS_EN     = 1;  // 09
  localparam int BIT_OVERRUN     = 3;  // 0A
  localparam int BIT_PAR_ERR     = 5;  // 0A
  localparam int BIT_RING_STAT   = 3;  // 0F
  localparam int BIT_SIG_DET     = 7;  // 0F
  localparam int BIT_PAR_SEL_LO  = 5;  // 11
  localparam int BIT_THR_LO      = 2;  // 13
  localparam int BIT_SLEEP       = 7;  // 15
  localparam int BIT_RING_WAKE   = 5;  // 15
  localparam int BIT_HOST_WAKE   = 4;  // 15
  localparam int BIT_RI_OVR_EN   = 6;  // 1A
  localparam int BIT_RI_OVR_LVL  = 5;  // 1A
  localparam int BIT_DIGIT_DET   = 4;  // 1B
  localparam int BIT_ONTIME      = 5;  // 1B
  localparam int BIT_RX_FULL     = 0;  // 1E
  localparam int BIT_RX_IRQ_EN   = 2;  // 1E
  localparam int BIT_RX_IRQ_ACT  = 6;  // 1E
  localparam int BIT_CFG_REQ     = 0;  // 1F
  localparam int BIT_CFG_IRQ_EN  = 2;  // 1F
  localparam int BIT_STAT_FLAG   = 3;  // 1F
  localparam int BIT_STAT_IRQ_EN = 4;  // 1F
  localparam int BIT_CFG_IRQ_ACT = 6;  // 1F
  localparam int BIT_STAT_IRQ_ACT = 7; // 1F

  // Status vector: 0A..0F then 1A, 1B, eight bits each
  localparam int STAT_W = 64;
  localparam int SV_RING_IDX = 6;
  localparam int SV_TONE_IDX = 7;

  // Parity methods
  typedef enum logic [1:0] {
    PAR_STUFF, PAR_SPACE, PAR_EVEN, PAR_ODD
  } parity_e;

  // Reset values of stored bytes
  localparam logic [7:0] RST_02 = 8'h80;
  localparam logic [7:0] RST_03 = 8'h10;
  localparam logic [7:0] RST_04 = 8'h40;
  localparam logic [7:0] RST_07 = 8'h80;
  localparam logic [7:0] RST_09 = 8'h20;
  localparam logic [7:0] RST_13 = 8'h90;
  localparam logic [7:0] RST_15 = 8'h30;
  localparam logic [7:0] RST_0  = 8'h00;

  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_TIME_NS    = 1000000;
  localparam int MS_CYCLES     = MS_TIME_NS / CLK_PERIOD_NS;
  localparam int RING_FMIN_HZ  = 15;
  localparam int RING_FMAX_HZ  = 68;
  localparam logic [6:0] RING_PMIN_MS = 7'(1000 / RING_FMAX_HZ);
  localparam logic [6:0] RING_PMAX_MS =
    7'((1000 + RING_FMIN_HZ - 1) / RING_FMIN_HZ);
  localparam int TURN_ON_BITS  = 8;

  function automatic logic [7:0] reg_reset(input int idx);
    case (idx)
      2:       reg_reset = RST_02;
      3:       reg_reset = RST_03;
      4:       reg_reset = RST_04;
      7:       reg_reset = RST_07;
      9:       reg_reset = RST_09;
      19:      reg_reset = RST_13;
      21:      reg_reset = RST_15;
      default: reg_reset = RST_0;
    endcase
  endfunction : reg_reset

endpackage : modem_hif_pkg

// [design/nrzi_codec.sv]
// NRZI encoder and decoder for the serial bit paths.
// Assumes bit strobes and bits arrive on clk_in from the modem core.
`timescale 1ns/1ns
module nrzi_codec (
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic enable_in,
  input  wire logic tx_stb_in,
  input  wire logic tx_bit_in,
  input  wire logic rx_stb_in,
  input  wire logic rx_bit_in,
  output logic      tx_line_out,
  output logic      rx_bit_out
);
  logic rx_prev_r;

  // Zero toggles the line, one holds it
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tx_line_out <= 1'b1;
      rx_prev_r   <= 1'b1;
      rx_bit_out  <= 1'b1;
    end else begin
      if (tx_stb_in)
        tx_line_out <= enable_in ? (tx_line_out ^ ~tx_bit_in)
                                 : tx_bit_in;
      if (rx_stb_in) begin
        rx_prev_r  <= rx_bit_in;
        rx_bit_out <= enable_in ? ~(rx_bit_in ^ rx_prev_r)
                                : rx_bit_in;
      end
    end
  end
endmodule : nrzi_codec

// [tb/modem_hif_monitor.sv]
// Port checker for the host interface bank, bound to every instance.
// Assumes one clock domain and the line and core inputs of the bench.
`timescale 1ns/1ns
module modem_hif_monitor (
  input wire logic        clk_in,
  input wire logic        nrst_in,
  input wire logic        cs_n_in,
  input wire logic        rd_n_in,
  input wire logic        cts_in,
  input wire logic        sync_mode_in,
  input wire logic        rx_bit_stb_in,
  input wire logic        rx_line_bit_in,
  input wire logic        tx_bit_stb_in,
  input wire logic        tx_user_bit_in,
  input wire logic        config_applied_in,
  input wire logic [modem_hif_pkg::STAT_W-1:0] core_status_in,
  input wire logic        irq_out,
  input wire logic        sleep_out,
  input wire logic        data_oe_out,
  input wire logic        rx_data_bit_out,
  input wire logic        tx_line_bit_out,
  input wire logic        tx_data_enable_out,
  input wire logic        line_signal_detect_out,
  input wire logic        config_update_request_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // Steady conditions that must force an output off
  sequence cts_low;  !cts_in [*4]; endsequence
  sequence sd_low;   !core_status_in[47] [*3]; endsequence
  sequence rd_idle;  rd_n_in [*5]; endsequence
  a_reset_quiet: assert property ($rose(nrst_in) |->
    !irq_out && !data_oe_out && !sleep_out) else $error("busy after reset");
  a_cts_gates_tx: assert property (cts_low |=> !tx_data_enable_out)
    else $error("transmit enabled without cts");
  a_nrz_rx_path: assert property (rx_bit_stb_in && !sync_mode_in |=>
    rx_data_bit_out == $past(rx_line_bit_in)) else $error("rx bit wrong");
  a_nrz_tx_path: assert property (tx_bit_stb_in && !sync_mode_in |->
    ##2 tx_line_bit_out == $past(tx_user_bit_in, 2))
    else $error("tx bit wrong");
  a_sd_pin_off: assert property (sd_low |=> !line_signal_detect_out)
    else $error("detect pin on without status");
  a_cfg_req_clears: assert property (
    config_update_request_out && config_applied_in |->
    ##[1:2] !config_update_request_out) else $error("request not cleared");
  a_oe_after_read: assert property ($rose(data_oe_out) |->
    $past(rd_n_in, 3) == 1'b0 && $past(cs_n_in, 3) == 1'b0)
    else $error("bus driven without read");
  a_oe_release: assert property (rd_idle |-> !data_oe_out)
    else $error("bus driven after read");
endmodule : modem_hif_monitor

bind modem_hif modem_hif_monitor mon (.*);

// [tb/host_cpu_model.sv]
// Host processor on the parallel register bus, one access at a time.
// Assumes the bank answers a read within 6 clocks of the strobe.
`timescale 1ns/1ns
module host_cpu_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  output logic            cs_n_out,
  output logic            rd_n_out,
  output logic            wr_n_out,
  output logic [4:0]      addr_out,
  output logic [7:0]      wdata_out,
  output logic            got_out,
  output logic [7:0]      got_data_out
);
  // Idle bus at time zero
  initial begin
    {cs_n_out, rd_n_out, wr_n_out} = 3'h7;
    {addr_out, wdata_out, got_out, got_data_out} = '0;
  end
  // Strobes held 6 clocks, then 6 idle; data parked inverted when idle
  task automatic access(input logic rd, input logic [4:0] a,
                        input logic [7:0] d);
    @(negedge clk_in);
    addr_out = a;
    wdata_out = d;
    cs_n_out = 1'b0;
    rd_n_out = !rd;
    wr_n_out = rd;
    repeat (6) @(negedge clk_in);
    got_data_out = rdata_in;
    got_out = rd;
    {cs_n_out, rd_n_out, wr_n_out} = 3'h7;
    wdata_out = ~d;
    @(negedge clk_in);
    got_out = 1'b0;
    repeat (5) @(negedge clk_in);
  endtask : access
endmodule : host_cpu_model

// [tb/tb_modem_host_interface_bits.sv]
// Self-checking bench for the host interface bank and its host model.
// Assumes the design package and the bound port checker.
`timescale 1ns/1ns
module tb_modem_host_interface_bits;
  import modem_hif_pkg::*;
  logic clk_in, nrst_in, cs_n_in, rd_n_in, wr_n_in, ring_detect_in, got;
  logic rts_pin_in, config_applied_in, ram_done_in, data_mode_in, cts_in;
  logic sync_mode_in, async_mode_in, hdlc_par_mode_in, rx_byte_valid_in;
  logic rx_par_bit_in, frame_check_bad_in, ontime_met_in, offtime_fail_in;
  logic tx_bit_stb_in, tx_user_bit_in, rx_bit_stb_in, rx_line_bit_in;
  logic data_oe_out, irq_out, ring_indicator_out, line_signal_detect_out;
  logic offhook_relay_out, relay_out_a, tx_line_bit_out, rx_data_bit_out;
  logic tx_parity_bit_out, config_update_request_out, sleep_out;
  logic answer_tone_suppress_out, tx_data_enable_out, e;
  logic [1:0]  energy_threshold_select_out;
  logic [4:0]  addr_in;
  logic [7:0]  data_in, data_out, rx_byte_in, tx_char_in, got_data, v;
  logic [12:0] note, exp_q[$];
  logic [63:0] core_status_in, status_mask_in;
  integer seed = 32'h839C;
  int fails = 0;
  int n_compared = 0;
  modem_hif #(.MS_TICK_CYCLES(10)) dut (.*);
  host_cpu_model host (.clk_in(clk_in), .rdata_in(data_out),
    .cs_n_out(cs_n_in), .rd_n_out(rd_n_in), .wr_n_out(wr_n_in),
    .addr_out(addr_in), .wdata_out(data_in), .got_out(got),
    .got_data_out(got_data));
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] s);
    n_compared++;
    if (s !== x) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  task automatic rd(input logic [4:0] a, input logic [7:0] x);
    exp_q.push_back({a, x});
    host.access(1'b1, a, 8'h00);
  endtask : rd
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    host.access(1'b0, a, d);
  endtask : wr
  task automatic pulse(ref logic s);
    @(negedge clk_in) s = 1'b1;
    @(negedge clk_in) s = 1'b0;
    repeat (4) @(negedge clk_in);
  endtask : pulse
  // One status bit up for a clock, then quiet
  task automatic stat_pulse(input int b);
    @(negedge clk_in) core_status_in[b] = 1'b1;
    @(negedge clk_in) core_status_in[b] = 1'b0;
    repeat (4) @(negedge clk_in);
  endtask : stat_pulse
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  // Each read returned by the host is matched against the oldest note
  always @(posedge clk_in) begin
    if (got) begin
      note = exp_q.pop_front();
      chk($sformatf("reg %h", note[12:8]), note[7:0], got_data);
    end
  end
  // Hang guard
  initial begin
    #100000;
    fails++;
    finish_test();
  end
  initial begin
    {ring_detect_in, rts_pin_in, config_applied_in, ram_done_in} = '0;
    {data_mode_in, sync_mode_in, async_mode_in, hdlc_par_mode_in} = '0;
    {cts_in, rx_byte_valid_in, rx_par_bit_in, frame_check_bad_in} = '0;
    {ontime_met_in, offtime_fail_in, tx_bit_stb_in, tx_user_bit_in} = '0;
    {rx_bit_stb_in, rx_line_bit_in, rx_byte_in, tx_char_in} = '0;
    {core_status_in, status_mask_in} = '0;
    nrst_in = 1'b0;
    repeat (3) @(negedge clk_in);
    nrst_in = 1'b1;
    // Reset values of control bytes
    rd(OFS_SIG_CTRL, RST_03);
    rd(OFS_LINE_CTRL, RST_04);
    rd(OFS_RELAY, RST_07);
    rd(OFS_DIAL, RST_09);
    rd(OFS_LEVEL, RST_13);
    rd(OFS_POWER, RST_15);
    // Relay bytes drive the relay pins
    repeat (3) begin
      v = 8'($random(seed));
      wr(OFS_RELAY, v);
      wr(OFS_LINE_CTRL, v & 8'hFB);
      chk("offhook", 8'(v[1]), 8'(offhook_relay_out));
      chk("relay a", 8'(v[7]), 8'(relay_out_a));
    end
    wr(OFS_DIAL, 8'hA0);
    chk("tone off", 8'h01, 8'(answer_tone_suppress_out));
    // Every parity method and threshold code
    async_mode_in = 1'b1;
    wr(OFS_ASYNC, 8'h08);
    for (int m = 0; m < 4; m++) begin
      tx_char_in = 8'($random(seed));
      wr(OFS_PARITY, 8'(m << 5));
      wr(OFS_LEVEL, 8'(m << 2));
      e = (m == 0) ? 1'b1 : (m == 1) ? 1'b0 : (m == 2) ? ^tx_char_in
        : ~^tx_char_in;
      chk("parity", 8'(e), 8'(tx_parity_bit_out));
      chk("threshold", 8'(m), 8'(energy_threshold_select_out));
    end
    async_mode_in = 1'b0;
    // Received byte, interrupt, overrun and frame error
    wr(OFS_BUF_IRQ, 8'h04);
    v = 8'($random(seed));
    rx_byte_in = v;
    pulse(rx_byte_valid_in);
    chk("irq", 8'h01, 8'(irq_out));
    rd(OFS_RX_DATA, v);
    chk("irq", 8'h00, 8'(irq_out));
    hdlc_par_mode_in = 1'b1;
    pulse(rx_byte_valid_in);
    frame_check_bad_in = 1'b1;
    pulse(rx_byte_valid_in);
    rd(OFS_STAT_LO, 8'h28);
    rd(OFS_RX_DATA, v);
    // Configuration request handshake
    wr(OFS_CFG_IRQ, 8'h05);
    chk("cfg req", 8'h01, 8'(config_update_request_out));
    pulse(config_applied_in);
    chk("cfg req", 8'h00, 8'(config_update_request_out));
    rd(OFS_CFG_IRQ, 8'h44);
    chk("irq", 8'h01, 8'(irq_out));
    // Masked and unmasked status changes, then a memory access
    status_mask_in[8] = 1'b1;
    wr(OFS_CFG_IRQ, 8'h10);
    stat_pulse(8);
    chk("irq", 8'h00, 8'(irq_out));
    status_mask_in[8] = 1'b0;
    stat_pulse(8);
    rd(OFS_CFG_IRQ, 8'h98);
    wr(OFS_CFG_IRQ, 8'h10);
    pulse(ram_done_in);
    chk("irq", 8'h01, 8'(irq_out));
    wr(OFS_CFG_IRQ, 8'h00);
    // Tone on-time flag, bit paths, detect pin, transmit gate
    pulse(ontime_met_in);
    rd(OFS_TONE, 8'h20);
    pulse(offtime_fail_in);
    rd(OFS_TONE, 8'h00);
    {rx_line_bit_in, tx_user_bit_in} = 2'($random(seed));
    pulse(rx_bit_stb_in);
    pulse(tx_bit_stb_in);
    // Inverted coding in sync mode: a zero toggles the line
    sync_mode_in = 1'b1;
    wr(OFS_LINE_CTRL, 8'h04);
    e = tx_line_bit_out;
    tx_user_bit_in = 1'b0;
    pulse(tx_bit_stb_in);
    chk("nrzi", 8'(e == 1'b0), 8'(tx_line_bit_out));
    sync_mode_in = 1'b0;
    core_status_in[47] = 1'b1;
    pulse(cts_in);
    chk("detect", 8'h01, 8'(line_signal_detect_out));
    wr(OFS_SIG_CTRL, 8'h00);
    chk("detect", 8'h00, 8'(line_signal_detect_out));
    cts_in = 1'b1;
    wr(OFS_TX_CTRL, 8'h01);
    chk("tx enable", 8'h01, 8'(tx_data_enable_out));
    rts_pin_in = 1'b1;
    wr(OFS_TX_CTRL, 8'h00);
    chk("tx enable", 8'h01, 8'(tx_data_enable_out));
    // Sleep without wake sources, then ring wake
    wr(OFS_POWER, 8'h80);
    wr(OFS_RELAY, 8'h00);
    chk("sleep", 8'h01, 8'(sleep_out));
    wr(OFS_POWER, 8'hA0);
    pulse(ring_detect_in);
    chk("sleep", 8'h00, 8'(sleep_out));
    wr(OFS_RING, 8'h40);
    chk("ring ind", 8'h01, 8'(ring_indicator_out));
    finish_test();
  end
endmodule : tb_modem_host_interface_bits
